// *** src/lkd_pkg.sv ***
package lkd_pkg;

  // Timing base
  localparam int CLK_HZ        = 20_000_000;
  localparam int TICK_MS       = 10;
  localparam int TICK_CYC      = CLK_HZ / 1000 * TICK_MS;
  localparam int TICKS_PER_S   = 1000 / TICK_MS;

  // Times in their own units
  localparam int DEB_MS        = 20;
  localparam int HOLD_FILL_S   = 5;
  localparam int HOLD_TEST_S   = 10;
  localparam int HOLD_INQ_MS   = 3000;
  localparam int FLASH_FAST_MS = 100;
  localparam int FLASH_SLOW_MS = 500;
  localparam int SHOW_S        = 10;
  localparam int FILL_CLR_MS   = 1000;
  localparam int TIGHT_STEP_S  = 3600;

  // Derived tick counts (least times round up)
  localparam int DEB_TK   = (DEB_MS + TICK_MS - 1) / TICK_MS;
  localparam int FILL_TK  = HOLD_FILL_S * TICKS_PER_S;
  localparam int TEST_TK  = HOLD_TEST_S * TICKS_PER_S;
  localparam int INQ_TK   = (HOLD_INQ_MS + TICK_MS - 1) / TICK_MS;
  localparam int FAST_TK  = FLASH_FAST_MS / TICK_MS;
  localparam int SLOW_TK  = FLASH_SLOW_MS / TICK_MS;
  localparam int SHOW_TK  = SHOW_S * TICKS_PER_S;
  localparam int FCLR_TK  = FILL_CLR_MS / TICK_MS;

  localparam int HOLD_W   = 11;
  localparam logic [3:0] TIGHT_MAX = 4'hA;

  // Pressure threshold flags from the sensor comparators
  typedef struct packed {
    logic alarm_low;     // At or below alarm pressure
    logic alarm_clear;   // Above alarm-off pressure
    logic refill_low;    // At or below refill-on pressure
    logic oper_reached;  // At or above operating pressure
  } lkd_press_t;

  typedef struct packed {
    logic green;
    logic red;
    logic yellow;
  } lkd_lamps_t;

  typedef enum logic [2:0] {
    GR_VERY_TIGHT,
    GR_TIGHT,
    GR_SUFFICIENT,
    GR_MAINT,
    GR_MAINT_URGENT
  } lkd_grade_t;

  typedef enum logic [1:0] {
    PS_IDLE,
    PS_FLASH_ON,
    PS_FLASH_OFF,
    PS_HOLD
  } lkd_pres_t;

endpackage

// *** src/lkd_key_hold.sv ***
`timescale 1ns/1ps
module lkd_key_hold
  import lkd_pkg::*;
#(
  parameter int HW     = HOLD_W,
  parameter int DEB_N  = DEB_TK
)(
  input  wire logic          clk_in,
  input  wire logic          rst_n_in,
  input  wire logic          tick_in,
  input  wire logic          key_in,
  output logic               pressed_out,
  output logic [HW-1:0]      hold_out,
  output logic               release_out
);

  if (DEB_N < 1 || DEB_N > 15 || HW < 2)
    $error("lkd_key_hold: bad parameters");

  logic          pressed_r, pressed_nxt;
  logic [3:0]    deb_r, deb_nxt;
  logic [HW-1:0] hold_r, hold_nxt;
  logic          rel_r, rel_nxt;

  always_comb
  begin
    pressed_nxt = pressed_r;
    deb_nxt     = deb_r;
    hold_nxt    = hold_r;
    rel_nxt     = 1'b0;
    if (key_in == pressed_r)
      deb_nxt = 4'h0;
    else if (tick_in)
    begin
      if (deb_r == 4'(DEB_N - 1))
      begin
        deb_nxt     = 4'h0;
        pressed_nxt = key_in;
        rel_nxt     = ~key_in;
      end
      else
        deb_nxt = deb_r + 4'h1;
    end
    if (!pressed_r)
      hold_nxt = '0;
    else if (tick_in && hold_r != '1)
      hold_nxt = hold_r + HW'(1);
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pressed_r <= 1'b0;
      deb_r     <= 4'h0;
      hold_r    <= '0;
      rel_r     <= 1'b0;
    end
    else
    begin
      pressed_r <= pressed_nxt;
      deb_r     <= deb_nxt;
      hold_r    <= hold_nxt;
      rel_r     <= rel_nxt;
    end
  end

  assign pressed_out = pressed_r;
  assign hold_out    = hold_r;
  assign release_out = rel_r;

endmodule

// *** src/lkd_key_alarm_ctrl.sv ***
// Behaviour
// - Mute key held ten seconds runs lamp and buzzer test until release.
// - Test starts only when pressure is above the alarm-clear threshold.
// - Fill key held five seconds starts fill, opens valve, flashes yellow.
// - Fill ends and yellow goes off once operating pressure is reached.
// - A further long fill press restarts filling after a completed fill.
// - Fill key held over ten seconds raises alarm, cleared shortly after release.
// - Held mute key flashes red fast; release presents tightness value.
// - Tightness presentation ends ten seconds later, pressure display returns.
// - Tightness valid only after one full automatic refill interval without filling.
// - Tightness is zero to ten flashes, graded in five bands.
// - External alarm output follows alarm, dropped by the mute key.
// - Alarm relay de-energised in alarm, same state as power loss.
// - Refill relay energised while refilling is active.
// - Brief mute press toggles buzzer in alarm; ignored otherwise and in malfunction.
// - Generator starts at refill-on pressure and stops at operating pressure.
// - Alarm raised once pressure falls to the alarm threshold.
`timescale 1ns/1ps
module lkd_key_alarm_ctrl
  import lkd_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC,
  parameter int STEP_S      = TIGHT_STEP_S
)(
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  input  wire logic        mute_key_in,
  input  wire logic        fill_key_in,
  input  wire lkd_press_t  press_in,
  input  wire logic        malfunction_in,
  output lkd_lamps_t       lamps_out,
  output logic             buzzer_out,
  output logic             ext_alarm_out,
  output logic             alarm_relay_out,
  output logic             refill_relay_out,
  output logic             fill_valve_out,
  output logic             generator_out,
  output logic [3:0]       tight_value_out,
  output logic             tight_valid_out,
  output logic             tight_show_out,
  output lkd_grade_t       tight_grade_out
);

  if (TICK_CYCLES < 2 || TICK_CYCLES >= 2**18 || STEP_S < 1 || STEP_S >= 2**16)
    $error("lkd_key_alarm_ctrl: bad parameters");

  logic rst_s1_r, rst_n_r;

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // Timing group: 10 ms tick, 1 s phase, fast flash phase
  logic [17:0] tick_cnt_r, tick_cnt_nxt;
  logic [6:0]  ph_r, ph_nxt;
  logic [4:0]  fph_r, fph_nxt;
  logic        tick, sec;

  assign tick = (tick_cnt_r == 18'(TICK_CYCLES - 1));
  assign sec  = tick && (ph_r == 7'(TICKS_PER_S - 1));

  always_comb
  begin
    tick_cnt_nxt = tick ? 18'h0_0000 : tick_cnt_r + 18'h0_0001;
    ph_nxt       = ph_r;
    fph_nxt      = fph_r;
    if (tick)
    begin
      ph_nxt  = (ph_r == 7'(TICKS_PER_S - 1)) ? 7'h00 : ph_r + 7'h01;
      fph_nxt = (fph_r == 5'(2 * FAST_TK - 1)) ? 5'h00 : fph_r + 5'h01;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      tick_cnt_r <= 18'h0_0000;
      ph_r       <= 7'h00;
      fph_r      <= 5'h00;
    end
    else
    begin
      tick_cnt_r <= tick_cnt_nxt;
      ph_r       <= ph_nxt;
      fph_r      <= fph_nxt;
    end
  end

  logic slow_on, fast_on;
  assign slow_on = (ph_r < 7'(SLOW_TK));
  assign fast_on = (fph_r < 5'(FAST_TK));

  logic              mk_pr, mk_rel, fk_pr, fk_rel;
  logic [HOLD_W-1:0] mk_hold, fk_hold;

  lkd_key_hold u_mute (
    .clk_in      (mclk_in),
    .rst_n_in    (rst_n_r),
    .tick_in     (tick),
    .key_in      (mute_key_in),
    .pressed_out (mk_pr),
    .hold_out    (mk_hold),
    .release_out (mk_rel)
  );

  lkd_key_hold u_fill (
    .clk_in      (mclk_in),
    .rst_n_in    (rst_n_r),
    .tick_in     (tick),
    .key_in      (fill_key_in),
    .pressed_out (fk_pr),
    .hold_out    (fk_hold),
    .release_out (fk_rel)
  );

  // Control group
  logic        alarm_r, alarm_nxt, muted_r, muted_nxt, test_r, test_nxt;
  logic        falm_r, falm_nxt, fill_r, fill_nxt, gen_r, gen_nxt;
  logic [6:0]  fclr_r, fclr_nxt;
  logic        idle_r, idle_nxt, taint_r, taint_nxt, tvalid_r, tvalid_nxt;
  logic [3:0]  score_r, score_nxt, tight_r, tight_nxt, left_r, left_nxt;
  logic [15:0] step_r, step_nxt;
  lkd_pres_t   pst_r, pst_nxt;
  logic [9:0]  show_r, show_nxt;
  logic [5:0]  fl_r, fl_nxt;
  lkd_lamps_t  lamps_r, lamps_nxt;
  logic        buz_r, buz_nxt, ext_r, ext_nxt, arel_r, arel_nxt;
  lkd_grade_t  grade_r, grade_nxt;
  logic        inquiry, any_alarm;

  assign inquiry   = mk_pr && (mk_hold >= HOLD_W'(INQ_TK)) && !test_r;
  assign any_alarm = alarm_r || falm_r || test_r;

  always_comb
  begin
    alarm_nxt  = alarm_r;
    muted_nxt  = muted_r;
    test_nxt   = test_r;
    falm_nxt   = falm_r;
    fclr_nxt   = fclr_r;
    fill_nxt   = fill_r;
    gen_nxt    = gen_r;
    idle_nxt   = idle_r;
    taint_nxt  = taint_r;
    tvalid_nxt = tvalid_r;
    score_nxt  = score_r;
    tight_nxt  = tight_r;
    step_nxt   = step_r;
    pst_nxt    = pst_r;
    show_nxt   = show_r;
    left_nxt   = left_r;
    fl_nxt     = fl_r;

    // Alarm at threshold, held until pressure recovers
    if (press_in.alarm_low)
      alarm_nxt = 1'b1;
    else if (press_in.alarm_clear)
      alarm_nxt = 1'b0;
    if (!alarm_nxt)
      muted_nxt = 1'b0;
    if (mk_rel && mk_hold < HOLD_W'(INQ_TK) && alarm_r && !malfunction_in)
      muted_nxt = ~muted_r;

    // Test while held, gated by pressure
    if (!mk_pr)
      test_nxt = 1'b0;
    else if (mk_hold >= HOLD_W'(TEST_TK) && press_in.alarm_clear && !alarm_r)
      test_nxt = 1'b1;

    // Fill-key overhold alarm, cleared shortly after release
    if (fk_pr && fk_hold > HOLD_W'(TEST_TK))
    begin
      falm_nxt = 1'b1;
      fclr_nxt = 7'h00;
    end
    else if (falm_r && !fk_pr && tick)
    begin
      if (fclr_r == 7'(FCLR_TK - 1))
        falm_nxt = 1'b0;
      else
        fclr_nxt = fclr_r + 7'h01;
    end

    if (press_in.oper_reached)
      fill_nxt = 1'b0;
    // Long press starts or restarts a fill
    else if (fk_pr && fk_hold == HOLD_W'(FILL_TK))
      fill_nxt = 1'b1;

    // Generator hysteresis between refill-on and operating pressure
    if (press_in.oper_reached)
      gen_nxt = 1'b0;
    else if (press_in.refill_low)
      gen_nxt = 1'b1;

    // Idle time of an automatic interval sets the score
    if (fill_r)
    begin
      taint_nxt = 1'b1;
      idle_nxt  = 1'b0;
    end
    else if (gen_r && !gen_nxt)
    begin
      idle_nxt  = 1'b1;
      taint_nxt = 1'b0;
      score_nxt = TIGHT_MAX;
      step_nxt  = 16'h0000;
    end
    else if (!gen_r && gen_nxt)
    begin
      if (idle_r && !taint_r)
      begin
        tight_nxt  = score_r;
        tvalid_nxt = 1'b1;
      end
      idle_nxt = 1'b0;
    end
    else if (idle_r && sec && score_r != 4'h0)
    begin
      if (step_r == 16'(STEP_S - 1))
      begin
        step_nxt  = 16'h0000;
        score_nxt = score_r - 4'h1;
      end
      else
        step_nxt = step_r + 16'h0001;
    end

    // Release after inquiry hold starts the presentation
    if (mk_rel && mk_hold >= HOLD_W'(INQ_TK) && mk_hold < HOLD_W'(TEST_TK))
    begin
      show_nxt = 10'h000;
      fl_nxt   = 6'h00;
      left_nxt = tvalid_r ? tight_r : 4'h0;
      pst_nxt  = (tvalid_r && tight_r != 4'h0) ? PS_FLASH_ON : PS_HOLD;
    end
    else if (tick && pst_r != PS_IDLE)
    begin
      show_nxt = show_r + 10'h001;
      fl_nxt   = fl_r + 6'h01;
      case (pst_r)
        PS_FLASH_ON:
          if (fl_r == 6'(SLOW_TK - 1))
          begin
            fl_nxt   = 6'h00;
            left_nxt = left_r - 4'h1;
            pst_nxt  = PS_FLASH_OFF;
          end
        PS_FLASH_OFF:
          if (fl_r == 6'(SLOW_TK - 1))
          begin
            fl_nxt  = 6'h00;
            pst_nxt = (left_r == 4'h0) ? PS_HOLD : PS_FLASH_ON;
          end
        default:
          fl_nxt = 6'h00;
      endcase
      if (show_r == 10'(SHOW_TK - 1))
        pst_nxt = PS_IDLE;
    end

    // Lamp priority: malfunction, pressure alarm, test, inquiry, fill
    lamps_nxt.green = 1'b1;
    if (malfunction_in)
      lamps_nxt.red = 1'b1;
    else if (alarm_r)
      lamps_nxt.red = muted_r ? slow_on : 1'b1;
    else if (test_r || falm_r)
      lamps_nxt.red = 1'b1;
    else if (inquiry)
      lamps_nxt.red = fast_on;
    else
      lamps_nxt.red = (pst_r == PS_FLASH_ON);
    if (malfunction_in)
      lamps_nxt.yellow = 1'b0;
    else if (alarm_r || test_r)
      lamps_nxt.yellow = 1'b1;
    else if (fill_r)
      lamps_nxt.yellow = slow_on;
    else
      lamps_nxt.yellow = gen_r;

    buz_nxt  = (any_alarm && !muted_r) || test_r;
    ext_nxt  = any_alarm && !muted_r;
    arel_nxt = !(alarm_r || falm_r || test_r);

    if (tight_r == 4'h0)
      grade_nxt = GR_VERY_TIGHT;
    else if (tight_r <= 4'h3)
      grade_nxt = GR_TIGHT;
    else if (tight_r <= 4'h6)
      grade_nxt = GR_SUFFICIENT;
    else if (tight_r <= 4'h8)
      grade_nxt = GR_MAINT;
    else
      grade_nxt = GR_MAINT_URGENT;
  end

  always_ff @(posedge mclk_in or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      alarm_r  <= 1'b0;
      muted_r  <= 1'b0;
      test_r   <= 1'b0;
      falm_r   <= 1'b0;
      fclr_r   <= 7'h00;
      fill_r   <= 1'b0;
      gen_r    <= 1'b0;
      idle_r   <= 1'b0;
      taint_r  <= 1'b0;
      tvalid_r <= 1'b0;
      score_r  <= 4'h0;
      tight_r  <= 4'h0;
      step_r   <= 16'h0000;
      pst_r    <= PS_IDLE;
      show_r   <= 10'h000;
      left_r   <= 4'h0;
      fl_r     <= 6'h00;
      lamps_r  <= '0;
      buz_r    <= 1'b0;
      ext_r    <= 1'b0;
      arel_r   <= 1'b0;
      grade_r  <= GR_VERY_TIGHT;
    end
    else
    begin
      alarm_r  <= alarm_nxt;
      muted_r  <= muted_nxt;
      test_r   <= test_nxt;
      falm_r   <= falm_nxt;
      fclr_r   <= fclr_nxt;
      fill_r   <= fill_nxt;
      gen_r    <= gen_nxt;
      idle_r   <= idle_nxt;
      taint_r  <= taint_nxt;
      tvalid_r <= tvalid_nxt;
      score_r  <= score_nxt;
      tight_r  <= tight_nxt;
      step_r   <= step_nxt;
      pst_r    <= pst_nxt;
      show_r   <= show_nxt;
      left_r   <= left_nxt;
      fl_r     <= fl_nxt;
      lamps_r  <= lamps_nxt;
      buz_r    <= buz_nxt;
      ext_r    <= ext_nxt;
      arel_r   <= arel_nxt;
      grade_r  <= grade_nxt;
    end
  end

  assign lamps_out        = lamps_r;
  assign buzzer_out       = buz_r;
  assign ext_alarm_out    = ext_r;
  assign alarm_relay_out  = arel_r;
  assign refill_relay_out = gen_r;
  assign fill_valve_out   = fill_r;
  assign generator_out    = gen_r;
  assign tight_value_out  = tight_r;
  assign tight_valid_out  = tvalid_r;
  assign tight_show_out   = (pst_r != PS_IDLE);
  assign tight_grade_out  = grade_r;

endmodule

// *** testbench/lkd_plant.sv ***
`timescale 1ns/1ps
module lkd_plant
  import lkd_pkg::*;
#(
  parameter logic [7:0] AL = 8'h0A,
  parameter logic [7:0] CL = 8'h14,
  parameter logic [7:0] RF = 8'h28,
  parameter logic [7:0] OP = 8'h3C
)(
  input  wire logic       mclk_in,
  input  wire logic       generator_in,
  input  wire logic       valve_in,
  input  wire logic       leak_in,
  input  wire logic       hold_in,
  input  wire logic [7:0] hold_val_in,
  output lkd_press_t      press_out
);
  logic [7:0] p_r = 8'h32;
  logic [7:0] p_nxt;
  logic [5:0] d_r = 6'h00;
  logic [5:0] d_nxt;
  // Gas supply raises pressure, a leak bleeds one step every 64 clocks
  always_comb
  begin
    p_nxt = p_r;
    d_nxt = d_r + 6'h01;
    if (hold_in)
      p_nxt = hold_val_in;
    else if ((generator_in || valve_in) && p_r < 8'h64)
      p_nxt = p_r + 8'h01;
    else if (leak_in && d_r == 6'h3F && p_r != 8'h00)
      p_nxt = p_r - 8'h01;
  end
  always_ff @(posedge mclk_in)
  begin
    p_r <= p_nxt;
    d_r <= d_nxt;
  end
  assign press_out = {p_r <= AL, p_r > CL, p_r <= RF, p_r >= OP};
endmodule

// *** testbench/lkd_chk_sva.sv ***
`timescale 1ns/1ps
module lkd_chk
  import lkd_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
)(
  input wire logic       mclk_in,
  input wire logic       rst_n_in,
  input wire lkd_press_t press_in,
  input wire lkd_lamps_t lamps_out,
  input wire logic       buzzer_out,
  input wire logic       ext_alarm_out,
  input wire logic       alarm_relay_out,
  input wire logic       refill_relay_out,
  input wire logic       fill_valve_out,
  input wire logic       generator_out,
  input wire logic [3:0] tight_value_out,
  input wire logic       tight_valid_out,
  input wire logic       tight_show_out,
  input wire lkd_grade_t tight_grade_out
);
  localparam int SHOW_LO = (SHOW_TK - 2) * TICK_CYCLES;
  localparam int SHOW_HI = (SHOW_TK + 2) * TICK_CYCLES;
  logic [2:0]  up_r;
  logic [2:0]  up_nxt;
  logic [31:0] sc_r;
  logic [31:0] sc_nxt;
  function automatic lkd_grade_t grade_of(input logic [3:0] v);
    if (v == 4'h0) return GR_VERY_TIGHT;
    if (v <= 4'h3) return GR_TIGHT;
    if (v <= 4'h6) return GR_SUFFICIENT;
    if (v <= 4'h8) return GR_MAINT;
    return GR_MAINT_URGENT;
  endfunction
  // Settles past the reset synchroniser; counts presentation length
  always_comb
  begin
    up_nxt = (up_r == 3'h7) ? up_r : up_r + 3'h1;
    sc_nxt = tight_show_out ? sc_r + 32'h0000_0001 : 32'h0000_0000;
  end
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      up_r <= 3'h0;
      sc_r <= 32'h0000_0000;
    end
    else
    begin
      up_r <= up_nxt;
      sc_r <= sc_nxt;
    end
  end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  chk_relay_follow: assert property (up_r == 3'h7 |-> refill_relay_out == generator_out)
    else $error("refill relay differs from generator");
  chk_gen_start: assert property (up_r == 3'h7 && press_in.refill_low && !press_in.oper_reached |=> generator_out)
    else $error("generator not started at refill pressure");
  chk_gen_stop: assert property (up_r == 3'h7 && press_in.oper_reached |=> !generator_out)
    else $error("generator not stopped at operating pressure");
  chk_fill_end: assert property (up_r == 3'h7 && press_in.oper_reached |=> !fill_valve_out)
    else $error("fill valve open at operating pressure");
  chk_alarm_relay: assert property (up_r == 3'h7 && press_in.alarm_low |-> ##2 !alarm_relay_out)
    else $error("alarm relay energised during alarm");
  chk_ext_alarm: assert property (up_r == 3'h7 && $rose(press_in.alarm_low) |-> ##2 ext_alarm_out && buzzer_out)
    else $error("external alarm or buzzer missing");
  chk_alarm_lamps: assert property (up_r == 3'h7 && $rose(press_in.alarm_low) |-> ##2 lamps_out.red && lamps_out.yellow)
    else $error("alarm lamps missing");
  chk_show_len: assert property ($fell(tight_show_out) |-> sc_r >= SHOW_LO && sc_r <= SHOW_HI)
    else $error("presentation length wrong");
  chk_grade_map: assert property (tight_valid_out && $stable(tight_value_out) |-> tight_grade_out == grade_of(tight_value_out))
    else $error("grade does not match score");
  chk_value_range: assert property (tight_valid_out |-> tight_value_out <= TIGHT_MAX)
    else $error("score above ten");
endmodule

// *** testbench/testbench.sv ***
`timescale 1ns/1ps
`define CHK(n,e,g) \
  begin \
    comparisons++; \
    if ((g) !== (e)) \
    begin \
      n_mismatch++; \
      $display("CHECK FAILED %s exp %0h got %0h", n, e, g); \
    end \
  end
module testbench
  import lkd_pkg::*;
;
  localparam int TK = 4;
  logic       mclk_in = 0, rst_n_in = 0, mute_key_in = 0, fill_key_in = 0, malfunction_in = 0;
  logic       leak = 0, hold = 1, r;
  logic [7:0] hval = 8'h32;
  lkd_press_t press_in;
  lkd_lamps_t lamps_out;
  lkd_grade_t tight_grade_out;
  logic [3:0] tight_value_out;
  logic       buzzer_out, ext_alarm_out, alarm_relay_out, refill_relay_out;
  logic       fill_valve_out, generator_out, tight_valid_out, tight_show_out;
  int         n_mismatch = 0, comparisons = 0, n;
  always #25 mclk_in = ~mclk_in;
  lkd_key_alarm_ctrl #(.TICK_CYCLES(TK), .STEP_S(1)) i_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .mute_key_in(mute_key_in), .fill_key_in(fill_key_in), .press_in(press_in), .malfunction_in(malfunction_in),
    .lamps_out(lamps_out), .buzzer_out(buzzer_out), .ext_alarm_out(ext_alarm_out),
    .alarm_relay_out(alarm_relay_out), .refill_relay_out(refill_relay_out), .fill_valve_out(fill_valve_out),
    .generator_out(generator_out), .tight_value_out(tight_value_out), .tight_valid_out(tight_valid_out),
    .tight_show_out(tight_show_out), .tight_grade_out(tight_grade_out));
  lkd_plant i_plant (.mclk_in(mclk_in), .generator_in(generator_out), .valve_in(fill_valve_out),
    .leak_in(leak), .hold_in(hold), .hold_val_in(hval), .press_out(press_in));
  task cyc(input int c); repeat (c) @(posedge mclk_in); #1; endtask
  task key(input bit f, input bit v, input int tk);
    if (f) fill_key_in = v; else mute_key_in = v;
    cyc(tk * TK);
  endtask
  task setp(input logic [7:0] v, input bit h); hval = v; hold = h; cyc(8); endtask
  task final_report;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task s_reset;
    cyc(5);
    `CHK("relay_rst", 1'b0, alarm_relay_out)
    `CHK("green_rst", 1'b0, lamps_out.green)
    rst_n_in = 1;
    cyc(6);
    `CHK("relay", 1'b1, alarm_relay_out)
    `CHK("green", 1'b1, lamps_out.green)
    `CHK("valid0", 1'b0, tight_valid_out)
  endtask
  task s_tight;
    setp(8'h23, 1);
    `CHK("gen", 1'b1, generator_out)
    `CHK("refill_rel", 1'b1, refill_relay_out)
    setp(8'h23, 0);
    for (int i = 0; i < 200 && generator_out; i++) cyc(1);
    leak = 1;
    for (int i = 0; i < 3000 && !generator_out; i++) cyc(1);
    leak = 0;
    cyc(4);
    `CHK("score", 4'h7, tight_value_out)
    `CHK("valid", 1'b1, tight_valid_out)
    `CHK("grade", GR_MAINT, tight_grade_out)
    for (int i = 0; i < 200 && generator_out; i++) cyc(1);
  endtask
  task s_inq;
    key(0, 1, 350);
    r = lamps_out.red;
    cyc(40);
    `CHK("fast", ~r, lamps_out.red)
    key(0, 1, 40);
    key(0, 0, 0);
    for (int i = 0; i < 100 && !tight_show_out; i++) cyc(1);
    `CHK("show", 1'b1, tight_show_out)
    n = 0;
    r = 0;
    for (int i = 0; i < 5000 && tight_show_out; i++)
    begin
      cyc(1);
      if (lamps_out.red && !r) n++;
      r = lamps_out.red;
    end
    `CHK("flashes", 7, n)
    `CHK("show_end", 1'b0, tight_show_out)
  endtask
  task s_fill;
    for (int k = 0; k < 2; k++)
    begin
      setp(8'h32, 1);
      key(1, 1, 600);
      `CHK("valve", 1'b1, fill_valve_out)
      r = lamps_out.yellow;
      cyc(200);
      `CHK("yel_flash", ~r, lamps_out.yellow)
      key(1, 0, 0);
      setp(8'h32, 0);
      cyc(30);
      `CHK("valve_end", 1'b0, fill_valve_out)
      `CHK("yel_off", 1'b0, lamps_out.yellow)
    end
  endtask
  task s_over;
    setp(8'h32, 1);
    key(1, 1, 1100);
    `CHK("ovr", 1'b0, alarm_relay_out)
    key(1, 0, 10);
    `CHK("ovr_hold", 1'b0, alarm_relay_out)
    cyc(150 * TK);
    `CHK("ovr_clr", 1'b1, alarm_relay_out)
    setp(8'h32, 0);
    cyc(30);
  endtask
  task s_test;
    setp(8'h32, 1);
    key(0, 1, 1100);
    `CHK("test_buz", 1'b1, buzzer_out)
    `CHK("test_rel", 1'b0, alarm_relay_out)
    `CHK("test_red", 1'b1, lamps_out.red)
    key(0, 0, 20);
    `CHK("test_end", 1'b0, buzzer_out)
    setp(8'h0F, 1);
    key(0, 1, 1100);
    `CHK("test_ref", 1'b0, buzzer_out)
    key(0, 0, 20);
  endtask
  task s_alarm;
    setp(8'h05, 1);
    `CHK("ext", 1'b1, ext_alarm_out)
    key(0, 1, 20);
    key(0, 0, 20);
    `CHK("muted", 1'b0, buzzer_out)
    `CHK("ext_off", 1'b0, ext_alarm_out)
    r = lamps_out.red;
    cyc(200);
    `CHK("mute_red", ~r, lamps_out.red)
    key(0, 1, 20);
    key(0, 0, 20);
    `CHK("unmuted", 1'b1, buzzer_out)
    malfunction_in = 1;
    key(0, 1, 20);
    key(0, 0, 20);
    `CHK("malf", 1'b1, buzzer_out)
    malfunction_in = 0;
    setp(8'h32, 1);
    `CHK("clr", 1'b1, alarm_relay_out)
    key(0, 1, 20);
    key(0, 0, 20);
    `CHK("normal", 1'b0, buzzer_out)
    setp(8'h32, 0);
  endtask
  initial
  begin
    #1;
    s_reset();
    s_tight();
    s_inq();
    s_fill();
    s_over();
    s_test();
    s_alarm();
    final_report();
  end
  initial
  begin
    repeat (60000) @(posedge mclk_in);
    n_mismatch++;
    final_report();
  end
endmodule
bind lkd_key_alarm_ctrl lkd_chk #(.TICK_CYCLES(TICK_CYCLES)) i_chk (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
  .press_in(press_in), .lamps_out(lamps_out), .buzzer_out(buzzer_out), .ext_alarm_out(ext_alarm_out),
  .alarm_relay_out(alarm_relay_out), .refill_relay_out(refill_relay_out), .fill_valve_out(fill_valve_out),
  .generator_out(generator_out), .tight_value_out(tight_value_out), .tight_valid_out(tight_valid_out),
  .tight_show_out(tight_show_out), .tight_grade_out(tight_grade_out));
